// File: src/atsc_pkg.sv
package atsc_pkg;

	localparam int unsigned NUM_CHANNELS = 26;
	localparam int unsigned NUM_CMP      = 4;
	localparam int unsigned NUM_PAIRS    = 7;
	localparam int unsigned ADDR_W       = 12;
	localparam int unsigned DATA_W       = 32;
	localparam int unsigned RES_W        = 16;
	localparam int unsigned SEL_W        = 5;
	localparam int unsigned RDY_W        = 10;
	localparam int unsigned RDY_FIRST    = 16;

	// Register offsets (byte addresses)
	localparam logic [11:0] OFF_READY_HIGH   = 12'h000;
	localparam logic [11:0] OFF_TRIG_BASE    = 12'h040;
	localparam logic [11:0] OFF_TRIG_END     = 12'h078;
	localparam logic [11:0] TRIG_STRIDE      = 12'h008;
	localparam logic [3:0]  CMP_PAGE         = 4'h1;
	localparam logic [4:0]  OFF_CMP_CON      = 5'h00;
	localparam logic [4:0]  OFF_CMP_LO       = 5'h04;
	localparam logic [4:0]  OFF_CMP_HI       = 5'h08;
	localparam logic [4:0]  OFF_CMP_ENL      = 5'h0c;
	localparam logic [4:0]  OFF_CMP_ENH      = 5'h10;

	// Field positions
	localparam int unsigned EVEN_SEL_LSB     = 0;
	localparam int unsigned ODD_SEL_LSB      = 8;
	localparam int unsigned CON_HIT_CHANNEL_NUMBER_LSB     = 8;
	localparam int unsigned CON_EN_BIT       = 7;
	localparam int unsigned CON_IE_BIT       = 6;
	localparam int unsigned CON_STAT_BIT     = 5;
	localparam int unsigned CON_WITHIN_LIMITS_ENABLE_BIT     = 4;
	localparam int unsigned CON_AT_OR_ABOVE_HIGH_ENABLE_BIT     = 3;
	localparam int unsigned CON_BELOW_HIGH_ENABLE_BIT     = 2;
	localparam int unsigned CON_AT_OR_ABOVE_LOW_ENABLE_BIT     = 1;
	localparam int unsigned CON_BELOW_LOW_ENABLE_BIT     = 0;
	localparam int unsigned MASK_LOW_W       = 16;
	localparam int unsigned MASK_HIGH_W      = 10;

	// Reset values
	localparam logic [4:0]  SEL_RESET        = 5'h00;
	localparam logic [15:0] LIMIT_RESET      = 16'h0000;

	// Trigger source codes
	localparam logic [4:0]  SRC_NONE         = 5'h00;
	localparam logic [4:0]  SRC_SW_COMMON    = 5'h01;
	localparam logic [4:0]  SRC_SW_LEVEL     = 5'h02;
	localparam logic [4:0]  SRC_RESERVED     = 5'h03;
	localparam logic [4:0]  SRC_PWM_FIRST    = 5'h04;
	localparam logic [4:0]  SRC_PWM_LAST     = 5'h13;
	localparam logic [4:0]  SRC_CCP_FIRST    = 5'h14;
	localparam logic [4:0]  SRC_CCP_LAST     = 5'h1a;
	localparam logic [4:0]  SRC_CCP_NINE     = 5'h1b;
	localparam logic [4:0]  SRC_CELL_ONE     = 5'h1c;
	localparam logic [4:0]  SRC_CELL_TWO     = 5'h1d;
	localparam logic [4:0]  SRC_SEQUENCER    = 5'h1e;
	localparam logic [4:0]  SRC_REMAP_PIN    = 5'h1f;

	typedef enum logic [8:0] {
		REG_NONE = 9'b000000001,
		REG_RDY  = 9'b000000010,
		REG_TRL  = 9'b000000100,
		REG_TRH  = 9'b000001000,
		REG_CCON = 9'b000010000,
		REG_CLO  = 9'b000100000,
		REG_CHI  = 9'b001000000,
		REG_CENL = 9'b010000000,
		REG_CENH = 9'b100000000
	} atsc_reg_kind_t;

	typedef struct packed {
		atsc_reg_kind_t kind;
		logic [2:0]     idx;
	} atsc_decode_t;

	typedef struct packed {
		logic       en;
		logic       ie;
		logic [4:0] cond;
	} atsc_cmp_cfg_t;

	typedef struct packed {
		logic              valid;
		logic              is_signed;
		logic [SEL_W-1:0]  channel;
		logic [RES_W-1:0]  data;
	} atsc_result_t;

	typedef struct packed {
		logic [15:0] pwm;
		logic [8:0]  ccp;
		logic        sw_common;
		logic        sw_level;
		logic        cell_one;
		logic        cell_two;
		logic        sequencer;
		logic        remap_pin;
	} atsc_trig_src_t;

endpackage : atsc_pkg

// File: src/atsc_adc_trigger_compare.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: Ready flags for channels 16..25 set on result arrival, read only, zero otherwise.
// R2: Upper six bits of high ready-status register always read zero.
// R3: Each selection register holds odd selector in 12:8, even in 4:0.
// R4: Code 0 disables, 1 common software, 2 level software, 3 reserved.
// R5: Codes 4..19 pick PWM generator triggers 1.1 up to 8.2 in order.
// R6: Codes 20..26 pick capture modules 1..7, code 27 picks module 9.
// R7: Codes 28,29 logic cells, 30 trigger sequencer, 31 remappable trigger pin.
// R8: Pair n holds channels 4n..4n+3; channels 24,25 in low register of pair 6.
// R9: Bits 15:13 and 7:5 of selection registers read zero.
// R10: Comparator enable at bit 7; clearing it disables and clears event flag.
// R11: Event writes the hit channel number into bits 12:8.
// R12: Event flag at bit 5 set on event, cleared when channel number is read.
// R13: Interrupt enable at bit 6 lets an event raise the common ADC interrupt.
// R14: Bit 4 enables event when low limit <= result < high limit.
// R15: Bit 3 enables event when result >= high limit.
// R16: Bit 2 enables event when result < high limit.
// R17: Bit 1 enables event when result >= low limit.
// R18: Bit 0 enables event when result < low limit.
// R19: Only results of channels enabled in the comparator channel mask are compared.
// R20: With several conditions enabled, any one true condition gives an event.
// R21: Limits held per comparator, compared in the result's own number format.
module atsc_adc_trigger_compare (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [11:0]               paddr,
	input  wire logic [31:0]               pwdata,
	input  wire logic [3:0]                pstrb,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire atsc_pkg::atsc_result_t    result_in,
	input  wire logic                      buffer_read_valid,
	input  wire logic [4:0]                buffer_read_channel,
	input  wire atsc_pkg::atsc_trig_src_t  trig_src,
	output logic      [25:0]               channel_trigger,
	output logic      [9:0]                upper_result_ready_flags,
	output logic                           common_adc_irq
);

	logic [4:0]               trig_sel_reg [atsc_pkg::NUM_CHANNELS];
	atsc_pkg::atsc_cmp_cfg_t  cmp_cfg_reg  [atsc_pkg::NUM_CMP];
	logic                     cmp_stat_reg [atsc_pkg::NUM_CMP];
	logic [4:0]               hit_chan_reg [atsc_pkg::NUM_CMP];
	logic [15:0]              cmp_lo_reg   [atsc_pkg::NUM_CMP];
	logic [15:0]              cmp_hi_reg   [atsc_pkg::NUM_CMP];
	logic [25:0]              cmp_mask_reg [atsc_pkg::NUM_CMP];
	logic [9:0]               rdy_reg;
	logic [25:0]              trig_out_reg;
	logic                     irq_reg;
	logic [31:0]              prdata_reg;
	logic                     pready_reg;
	logic                     pslverr_reg;

	atsc_pkg::atsc_decode_t   dec;
	logic                     setup_phase;
	logic                     access_done;
	logic                     wr_done;
	logic                     rd_done;
	logic [31:0]              rd_value;
	logic [31:0]              src_vec;
	logic [3:0]               cmp_hit;

	function automatic atsc_pkg::atsc_decode_t decode(input logic [11:0] a);
		atsc_pkg::atsc_decode_t d;
		logic [11:0]            rel;
		d.kind = atsc_pkg::REG_NONE;
		d.idx  = 3'd0;
		rel    = a - atsc_pkg::OFF_TRIG_BASE;
		if (a[1:0] == 2'b00) begin
			if (a == atsc_pkg::OFF_READY_HIGH) begin
				d.kind = atsc_pkg::REG_RDY;
			end else if (a >= atsc_pkg::OFF_TRIG_BASE
					&& a < atsc_pkg::OFF_TRIG_END) begin
				d.idx = rel[5:3];
				if (!rel[2]) begin
					d.kind = atsc_pkg::REG_TRL;
				end else if (rel[5:3] != 3'd6) begin
					d.kind = atsc_pkg::REG_TRH; // R8
				end
			end else if (a[11:8] == atsc_pkg::CMP_PAGE && a[7] == 1'b0) begin
				d.idx = {1'b0, a[6:5]};
				unique case (a[4:0])
					atsc_pkg::OFF_CMP_CON: d.kind = atsc_pkg::REG_CCON;
					atsc_pkg::OFF_CMP_LO:  d.kind = atsc_pkg::REG_CLO;
					atsc_pkg::OFF_CMP_HI:  d.kind = atsc_pkg::REG_CHI;
					atsc_pkg::OFF_CMP_ENL: d.kind = atsc_pkg::REG_CENL;
					atsc_pkg::OFF_CMP_ENH: d.kind = atsc_pkg::REG_CENH;
					default:               d.kind = atsc_pkg::REG_NONE;
				endcase
			end
		end
		return d;
	endfunction : decode

	// Byte-lane merge of a 16-bit field
	function automatic logic [15:0] merge16(
		input logic [15:0] old_v,
		input logic [15:0] new_v,
		input logic [1:0]  strb
	);
		logic [15:0] r;
		r[7:0]  = strb[0] ? new_v[7:0]  : old_v[7:0];
		r[15:8] = strb[1] ? new_v[15:8] : old_v[15:8];
		return r;
	endfunction : merge16

	// Less-than in the result's own format
	function automatic logic less_than(
		input logic [15:0] a,
		input logic [15:0] b,
		input logic        sgn
	);
		return sgn ? ($signed(a) < $signed(b)) : (a < b); // R21
	endfunction : less_than

	assign dec         = decode(paddr);
	assign setup_phase = psel && !penable;
	assign access_done = psel && penable && pready_reg;
	assign wr_done     = access_done && pwrite;
	assign rd_done     = access_done && !pwrite;

	// Trigger source vector indexed by selector code
	always_comb begin
		src_vec = 32'h0000_0000;
		src_vec[atsc_pkg::SRC_NONE]      = 1'b0; // R4
		src_vec[atsc_pkg::SRC_SW_COMMON] = trig_src.sw_common; // R4
		src_vec[atsc_pkg::SRC_SW_LEVEL]  = trig_src.sw_level; // R4
		src_vec[atsc_pkg::SRC_RESERVED]  = 1'b0; // R4
		src_vec[atsc_pkg::SRC_PWM_LAST:atsc_pkg::SRC_PWM_FIRST] =
			trig_src.pwm; // R5
		src_vec[atsc_pkg::SRC_CCP_LAST:atsc_pkg::SRC_CCP_FIRST] =
			trig_src.ccp[6:0]; // R6
		src_vec[atsc_pkg::SRC_CCP_NINE]  = trig_src.ccp[8]; // R6
		src_vec[atsc_pkg::SRC_CELL_ONE]  = trig_src.cell_one; // R7
		src_vec[atsc_pkg::SRC_CELL_TWO]  = trig_src.cell_two; // R7
		src_vec[atsc_pkg::SRC_SEQUENCER] = trig_src.sequencer; // R7
		src_vec[atsc_pkg::SRC_REMAP_PIN] = trig_src.remap_pin; // R7
	end

	// Comparator event detection
	always_comb begin
		logic        lt_lo;
		logic        lt_hi;
		logic [4:0]  c;
		logic        any;
		lt_lo   = 1'b0;
		lt_hi   = 1'b0;
		c       = 5'h00;
		any     = 1'b0;
		cmp_hit = 4'h0;
		for (int x = 0; x < atsc_pkg::NUM_CMP; x++) begin
			lt_lo = less_than(result_in.data, cmp_lo_reg[x],
				result_in.is_signed);
			lt_hi = less_than(result_in.data, cmp_hi_reg[x],
				result_in.is_signed);
			c = cmp_cfg_reg[x].cond;
			any = (c[atsc_pkg::CON_WITHIN_LIMITS_ENABLE_BIT] && !lt_lo && lt_hi) // R14
				|| (c[atsc_pkg::CON_AT_OR_ABOVE_HIGH_ENABLE_BIT] && !lt_hi) // R15
				|| (c[atsc_pkg::CON_BELOW_HIGH_ENABLE_BIT] && lt_hi) // R16
				|| (c[atsc_pkg::CON_AT_OR_ABOVE_LOW_ENABLE_BIT] && !lt_lo) // R17
				|| (c[atsc_pkg::CON_BELOW_LOW_ENABLE_BIT] && lt_lo); // R18 R20
			cmp_hit[x] = result_in.valid && cmp_cfg_reg[x].en
				&& (result_in.channel < 5'(atsc_pkg::NUM_CHANNELS))
				&& cmp_mask_reg[x][result_in.channel] // R19
				&& any;
		end
	end

	// Read multiplexer
	always_comb begin
		int unsigned b;
		b        = 0;
		rd_value = 32'h0000_0000;
		unique case (dec.kind)
			atsc_pkg::REG_RDY: begin
				rd_value[atsc_pkg::RDY_W-1:0] = rdy_reg; // R2
			end
			atsc_pkg::REG_TRL,
			atsc_pkg::REG_TRH: begin
				b = 4 * int'(dec.idx)
					+ ((dec.kind == atsc_pkg::REG_TRH) ? 2 : 0); // R8
				rd_value[atsc_pkg::EVEN_SEL_LSB +: 5] = trig_sel_reg[b]; // R3 R9
				rd_value[atsc_pkg::ODD_SEL_LSB +: 5]  = trig_sel_reg[b+1]; // R3 R9
			end
			atsc_pkg::REG_CCON: begin
				rd_value[atsc_pkg::CON_HIT_CHANNEL_NUMBER_LSB +: 5] = hit_chan_reg[dec.idx[1:0]];
				rd_value[atsc_pkg::CON_EN_BIT]   = cmp_cfg_reg[dec.idx[1:0]].en;
				rd_value[atsc_pkg::CON_IE_BIT]   = cmp_cfg_reg[dec.idx[1:0]].ie;
				rd_value[atsc_pkg::CON_STAT_BIT] = cmp_stat_reg[dec.idx[1:0]];
				rd_value[4:0] = cmp_cfg_reg[dec.idx[1:0]].cond;
			end
			atsc_pkg::REG_CLO: begin
				rd_value[15:0] = cmp_lo_reg[dec.idx[1:0]];
			end
			atsc_pkg::REG_CHI: begin
				rd_value[15:0] = cmp_hi_reg[dec.idx[1:0]];
			end
			atsc_pkg::REG_CENL: begin
				rd_value[15:0] =
					cmp_mask_reg[dec.idx[1:0]][atsc_pkg::MASK_LOW_W-1:0];
			end
			atsc_pkg::REG_CENH: begin
				rd_value[atsc_pkg::MASK_HIGH_W-1:0] =
					cmp_mask_reg[dec.idx[1:0]][25:atsc_pkg::MASK_LOW_W];
			end
			atsc_pkg::REG_NONE: begin
				rd_value = 32'h0000_0000;
			end
		endcase
	end

	// APB answer: zero wait states, data and error sampled in setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= setup_phase;
			pslverr_reg <= setup_phase && (dec.kind == atsc_pkg::REG_NONE);
			if (setup_phase && !pwrite) begin
				prdata_reg <= rd_value;
			end
		end
	end

	// Trigger selector storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < atsc_pkg::NUM_CHANNELS; i++) begin
				trig_sel_reg[i] <= atsc_pkg::SEL_RESET;
			end
		end else if (wr_done && (dec.kind == atsc_pkg::REG_TRL
				|| dec.kind == atsc_pkg::REG_TRH)) begin
			for (int i = 0; i < atsc_pkg::NUM_CHANNELS; i += 2) begin
				if (i == 4 * int'(dec.idx)
						+ ((dec.kind == atsc_pkg::REG_TRH) ? 2 : 0)) begin // R8
					if (pstrb[0]) begin
						trig_sel_reg[i] <= pwdata[atsc_pkg::EVEN_SEL_LSB +: 5]; // R3
					end
					if (pstrb[1]) begin
						trig_sel_reg[i+1] <= pwdata[atsc_pkg::ODD_SEL_LSB +: 5]; // R3
					end
				end
			end
		end
	end

	// Per-channel trigger routing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_out_reg <= 26'h0;
		end else begin
			for (int i = 0; i < atsc_pkg::NUM_CHANNELS; i++) begin
				trig_out_reg[i] <= src_vec[trig_sel_reg[i]]; // R4 R5 R6 R7
			end
		end
	end

	// Upper channel ready flags; arrival wins over a buffer read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdy_reg <= 10'h000;
		end else begin
			for (int i = 0; i < atsc_pkg::RDY_W; i++) begin
				if (result_in.valid
						&& result_in.channel == 5'(atsc_pkg::RDY_FIRST + i)) begin
					rdy_reg[i] <= 1'b1; // R1
				end else if (buffer_read_valid
						&& buffer_read_channel == 5'(atsc_pkg::RDY_FIRST + i)) begin
					rdy_reg[i] <= 1'b0; // R1
				end
			end
		end
	end

	// Comparator configuration, limits and channel masks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int x = 0; x < atsc_pkg::NUM_CMP; x++) begin
				cmp_cfg_reg[x]  <= '0;
				cmp_lo_reg[x]   <= atsc_pkg::LIMIT_RESET;
				cmp_hi_reg[x]   <= atsc_pkg::LIMIT_RESET;
				cmp_mask_reg[x] <= 26'h0;
			end
		end else if (wr_done) begin
			for (int x = 0; x < atsc_pkg::NUM_CMP; x++) begin
				if (dec.idx[1:0] == 2'(x)) begin
					unique case (dec.kind)
						atsc_pkg::REG_CCON: begin
							if (pstrb[0]) begin
								cmp_cfg_reg[x].en   <= pwdata[atsc_pkg::CON_EN_BIT]; // R10
								cmp_cfg_reg[x].ie   <= pwdata[atsc_pkg::CON_IE_BIT]; // R13
								cmp_cfg_reg[x].cond <= pwdata[4:0];
							end
						end
						atsc_pkg::REG_CLO: begin
							cmp_lo_reg[x] <= merge16(cmp_lo_reg[x], pwdata[15:0],
								pstrb[1:0]); // R21
						end
						atsc_pkg::REG_CHI: begin
							cmp_hi_reg[x] <= merge16(cmp_hi_reg[x], pwdata[15:0],
								pstrb[1:0]); // R21
						end
						atsc_pkg::REG_CENL: begin
							cmp_mask_reg[x][15:0] <= merge16(cmp_mask_reg[x][15:0],
								pwdata[15:0], pstrb[1:0]); // R19
						end
						atsc_pkg::REG_CENH: begin
							if (pstrb[0]) begin
								cmp_mask_reg[x][23:16] <= pwdata[7:0]; // R19
							end
							if (pstrb[1]) begin
								cmp_mask_reg[x][25:24] <= pwdata[9:8]; // R19
							end
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	// Event flag and captured channel number
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int x = 0; x < atsc_pkg::NUM_CMP; x++) begin
				cmp_stat_reg[x] <= 1'b0;
				hit_chan_reg[x] <= 5'h00;
			end
		end else begin
			for (int x = 0; x < atsc_pkg::NUM_CMP; x++) begin
				if (!cmp_cfg_reg[x].en) begin
					cmp_stat_reg[x] <= 1'b0; // R10
				end else if (cmp_hit[x]) begin
					cmp_stat_reg[x] <= 1'b1; // R12
					hit_chan_reg[x] <= result_in.channel; // R11
				end else if (rd_done && dec.kind == atsc_pkg::REG_CCON
						&& prdata_reg[atsc_pkg::CON_STAT_BIT]
						&& dec.idx[1:0] == 2'(x)) begin
					cmp_stat_reg[x] <= 1'b0; // R12
				end
			end
		end
	end

	// Common interrupt request pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= 1'b0;
			for (int x = 0; x < atsc_pkg::NUM_CMP; x++) begin
				if (cmp_hit[x] && cmp_cfg_reg[x].ie) begin
					irq_reg <= 1'b1; // R13
				end
			end
		end
	end

	assign prdata                   = prdata_reg;
	assign pready                   = pready_reg;
	assign pslverr                  = pslverr_reg;
	assign channel_trigger          = trig_out_reg;
	assign upper_result_ready_flags = rdy_reg;
	assign common_adc_irq           = irq_reg;

endmodule : atsc_adc_trigger_compare

`default_nettype wire

// File: testbench/atsc_adc_trigger_compare_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module atsc_adc_trigger_compare_monitor (
	input wire logic                     pclk,
	input wire logic                     presetn,
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic [11:0]              paddr,
	input wire logic [31:0]              prdata,
	input wire logic                     pready,
	input wire logic                     pslverr,
	input wire atsc_pkg::atsc_result_t   result_in,
	input wire atsc_pkg::atsc_trig_src_t trig_src,
	input wire logic [25:0]              channel_trigger,
	input wire logic [9:0]               upper_result_ready_flags,
	input wire logic                     common_adc_irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rdy_set;
		result_in.valid && result_in.channel inside {[16:25]}
		|=> upper_result_ready_flags[$past(result_in.channel) - 5'h10];
	endproperty
	a_rdy_set: assert property (p_rdy_set)
		else $error("ready flag not set");
	property p_rdy_cause;
		!result_in.valid |=> (upper_result_ready_flags
			& ~$past(upper_result_ready_flags)) == 10'h0;
	endproperty
	a_rdy_cause: assert property (p_rdy_cause)
		else $error("ready flag set without result");
	property p_stat_rsvd;
		pready && !pwrite && paddr == 12'h000 |-> prdata[31:10] == 22'h0;
	endproperty
	a_stat_rsvd: assert property (p_stat_rsvd)
		else $error("ready status upper bits not zero");
	property p_trig_rsvd;
		pready && !pwrite && paddr inside {[12'h040:12'h078]}
		|-> prdata[15:13] == 3'h0 && prdata[7:5] == 3'h0;
	endproperty
	a_trig_rsvd: assert property (p_trig_rsvd)
		else $error("selector unused bits not zero");
	property p_trig_idle;
		trig_src == '0 |=> channel_trigger == 26'h0;
	endproperty
	a_trig_idle: assert property (p_trig_idle)
		else $error("trigger without source");
	property p_irq_cause;
		common_adc_irq |-> $past(result_in.valid);
	endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("interrupt without result");
	property p_setup_ready;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_setup_ready: assert property (p_setup_ready)
		else $error("access cycle answer wrong");
	property p_misalign;
		psel && !penable && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0;
	endproperty
	a_misalign: assert property (p_misalign)
		else $error("misaligned access not refused");
	c_irq: cover property (common_adc_irq);
	c_err: cover property (pslverr);
	c_rdy: cover property (upper_result_ready_flags == 10'h3ff);
endmodule : atsc_adc_trigger_compare_monitor
bind atsc_adc_trigger_compare atsc_adc_trigger_compare_monitor u_mon (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
	.pslverr, .result_in, .trig_src, .channel_trigger,
	.upper_result_ready_flags, .common_adc_irq
);
`default_nettype wire

// File: testbench/atsc_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module atsc_far_side (
	input wire logic                     pclk,
	output var atsc_pkg::atsc_result_t   result_in,
	output var atsc_pkg::atsc_trig_src_t trig_src
);
	initial begin
		result_in = '0;
		trig_src = '0;
	end
	// One result pulse, then the payload is inverted so stale data never matches
	task automatic send(input logic [4:0] ch, input logic [15:0] d,
		input logic s);
		@(posedge pclk);
		result_in <= {1'h1, s, ch, d};
		@(posedge pclk);
		result_in <= {1'h0, ~s, ~ch, ~d};
	endtask : send
	task automatic set_src(input atsc_pkg::atsc_trig_src_t s);
		@(posedge pclk);
		trig_src <= s;
	endtask : set_src
endmodule : atsc_far_side
`default_nettype wire

// File: testbench/atsc_adc_trigger_compare_tb.sv
`timescale 1ns/1ps
`default_nettype none
module atsc_adc_trigger_compare_tb;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, pready, pslverr, err, common_adc_irq;
	logic buffer_read_valid = 1'h0;
	logic [4:0] buffer_read_channel = 5'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h4e18;
	logic [3:0] pstrb = 4'h0;
	logic [25:0] channel_trigger;
	logic [9:0] upper_result_ready_flags;
	atsc_pkg::atsc_result_t result_in;
	atsc_pkg::atsc_trig_src_t trig_src;
	int err_total = 0, checks_done = 0;
	always #5 pclk = ~pclk;
	atsc_adc_trigger_compare dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .result_in,
		.buffer_read_valid, .buffer_read_channel, .trig_src,
		.channel_trigger, .upper_result_ready_flags, .common_adc_irq);
	atsc_far_side far (.pclk, .result_in, .trig_src);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic src_bit(atsc_pkg::atsc_trig_src_t s, int c);
		if (c >= 4 && c <= 19) return s.pwm[c-4];
		if (c >= 20 && c <= 26) return s.ccp[c-20];
		case (c)
			1: return s.sw_common;
			2: return s.sw_level;
			27: return s.ccp[8];
			28: return s.cell_one;
			29: return s.cell_two;
			30: return s.sequencer;
			31: return s.remap_pin;
			default: return 1'h0;
		endcase
	endfunction : src_bit
	function automatic logic ev(logic [4:0] c, logic [15:0] v, l, h,
		logic s);
		logic gl, lh;
		gl = s ? $signed(v) >= $signed(l) : v >= l;
		lh = s ? $signed(v) < $signed(h) : v < h;
		return (c[4] & gl & lh) | (c[3] & !lh) | (c[2] & lh) | (c[1] & gl)
			| (c[0] & !gl);
	endfunction : ev
	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	task automatic chk(input string n, input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hf;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) begin
			err_total++;
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	initial begin
		repeat (40000) @(posedge pclk);
		err_total++;
		test_done();
	end
	initial begin
		logic [31:0] d;
		logic [25:0] mk;
		logic [15:0] lo, hi, v;
		logic [11:0] a;
		logic [4:0] cond;
		logic ie, s, e;
		int ch;
		atsc_pkg::atsc_trig_src_t ts;
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, 12'h000, 32'h0);
		chk("ready", rd, 32'h0);
		for (int n = 0; n < 14; n++) begin
			a = 12'h040 + 12'(4 * n);
			d = rnd();
			apb(1'h1, a, d);
			apb(1'h0, a, 32'h0);
			chk("trigsel", rd, n == 13 ? 32'h0 : d & 32'h1f1f);
			chk("trigerr", err, n == 13);
		end
		apb(1'h0, 12'h042, 32'h0);
		chk("misalign", err, 32'h1);
		apb(1'h1, 12'h800, 32'h1);
		chk("unmapped", err, 32'h1);
		$display("register test done");
		for (int c = 0; c < 64; c++) begin
			ch = rnd() % 26;
			a = 12'h040 + 12'(8 * (ch / 4) + 4 * ((ch % 4) / 2));
			apb(1'h1, a, 32'(c % 32) << (8 * (ch % 2)));
			d = rnd();
			ts = d[30:0];
			far.set_src(ts);
			@(posedge pclk);
			#1;
			chk("trigger", channel_trigger[ch], src_bit(ts, c % 32));
		end
		far.set_src('0);
		$display("trigger test done");
		for (int c = 14; c < 27; c++) far.send(5'(c), 16'(rnd()), 1'h0);
		apb(1'h1, 12'h000, 32'h0);
		apb(1'h0, 12'h000, 32'h0);
		chk("ready", rd, 32'h3ff);
		chk("flags", upper_result_ready_flags, 32'h3ff);
		@(posedge pclk);
		buffer_read_valid <= 1'h1;
		buffer_read_channel <= 5'h14;
		@(posedge pclk);
		buffer_read_valid <= 1'h0;
		apb(1'h0, 12'h000, 32'h0);
		chk("ready clr", rd, 32'h3ef);
		$display("ready test done");
		for (int k = 0; k < 40; k++) begin
			a = 12'h100 + 12'(32 * (rnd() % 4));
			lo = 16'(rnd());
			hi = 16'(rnd());
			ch = rnd() % 26;
			d = rnd();
			cond = d[4:0];
			ie = d[5];
			s = d[6];
			case (k % 5)
				0: v = lo;
				1: v = lo - 16'h1;
				2: v = hi;
				3: v = hi - 16'h1;
				default: v = 16'(rnd());
			endcase
			mk = (k % 7 == 6) ? ~(26'h1 << ch) : 26'h3ffffff;
			e = mk[ch] & ev(cond, v, lo, hi, s);
			apb(1'h1, a + 12'h4, 32'(lo));
			apb(1'h1, a + 12'h8, 32'(hi));
			apb(1'h1, a + 12'hc, 32'(mk[15:0]));
			apb(1'h1, a + 12'h10, 32'(mk[25:16]));
			apb(1'h1, a, {24'h0, 1'h1, ie, 1'h0, cond});
			far.send(5'(ch), v, s);
			#1;
			chk("irq", common_adc_irq, e & ie);
			if (k % 2 == 1) begin
				apb(1'h1, a, 32'h0);
				apb(1'h0, a, 32'h0);
				chk("disabled", rd[7:0], 32'h0);
			end else begin
				apb(1'h0, a, 32'h0);
				d = {19'h0, 5'(ch), 1'h1, ie, e, cond};
				chk("control", rd & (e ? 32'h1fff : 32'hff), d & (e ? 32'h1fff : 32'hff));
				apb(1'h0, a, 32'h0);
				chk("stat clr", rd[5], 32'h0);
				apb(1'h1, a, 32'h0);
			end
		end
		$display("comparator test done");
		test_done();
	end
endmodule : atsc_adc_trigger_compare_tb
`default_nettype wire
